// >>> include/acr_pkg.sv
// Summary of operation
// RQ1: conversion yields a 12-bit result in two bytes
// RQ2: justify bit picks left or right packing
// RQ3: unused result bits read as zero
// RQ4: results hold while converter is disabled
// RQ5: start bit high then low starts one conversion
// RQ6: busy set at start, cleared at completion
// RQ7: busy bit is read-only to software
// RQ8: enable low powers converter down
// RQ9: channel code 0 and 1 route pins, others float
// RQ10: software uses external source codes for pins
// RQ11: analog enable gives pin to converter
// RQ12: pull-high removed on analog pins
// RQ13: source and channel fields pick the input jointly
// RQ14: main control register clears at reset
// RQ15: source code 1 internal, 2 to 4 ground
// RQ16: completion sets interrupt flag, raises irq if enabled
// RQ17: clock select divides by powers of two to 128
// RQ18: both result bytes update at completion only
package acr_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_RES_LO   = 8'h00;
  localparam logic [7:0] OFF_RES_HI   = 8'h04;
  localparam logic [7:0] OFF_CTRL     = 8'h08;
  localparam logic [7:0] OFF_SRC      = 8'h0c;
  localparam logic [7:0] OFF_ACE      = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;

  // ==========================================================
  // fields and reset values
  localparam int         CTRL_START = 7;
  localparam int         CTRL_BUSY  = 6;
  localparam int         CTRL_EN    = 5;
  localparam int         CTRL_JUST  = 4;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_SRC    = 8'h00;
  localparam logic [1:0] RST_ACE    = 2'h0;
  localparam logic [1:0] RST_DIV    = 2'h0;

  localparam logic [2:0] INS_INTERNAL = 3'h1;
  localparam logic [2:0] INS_GND_LO   = 3'h2;
  localparam logic [2:0] INS_GND_HI   = 3'h4;
  localparam logic [3:0] CS_PIN0      = 4'h0;
  localparam logic [3:0] CS_PIN1      = 4'h1;

  // ==========================================================
  // timing
  localparam int         CLK_NS     = 10;
  localparam int         SETTLE_NS  = 30;
  localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SAR_FIRST = 12'h800;
  localparam logic [3:0]  SAR_MSB   = 4'hb;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b01,
    ACR_CONV = 2'b10
  } acr_state_e;

  typedef struct packed {
    logic pin0;
    logic pin1;
    logic internal;
    logic ground;
  } acr_route_s;

  typedef struct packed {
    logic analog_en;
    logic pullup_en;
  } acr_pin_s;

endpackage : acr_pkg

// >>> rtl/acr_top.sv
`timescale 1ns/10ps
`default_nettype none
module acr_top #(
  parameter int RES_BITS = 12,
  parameter int NUM_PINS = 2
) (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              cmp_in,
  output logic      [11:0]                       dac_code,
  output logic                                   adc_power_on,
  output logic      [1:0]                        ref_sel,
  output acr_pkg::acr_route_s                    route,
  input  wire logic [NUM_PINS-1:0]               pin_pullup_req,
  output acr_pkg::acr_pin_s [NUM_PINS-1:0]       pin_ctl,
  output logic                                   conv_busy,
  output logic                                   irq
);

  // ==========================================================
  // elaboration checks
  if (RES_BITS != 12) begin : g_bad_res
    $error("result layout is fixed at 12 bits");
  end
  if (NUM_PINS != 2) begin : g_bad_pins
    $error("channel decode serves exactly two pins");
  end

  // ==========================================================
  // state
  logic [7:0]          ctrl_reg,  ctrl_next;
  logic [7:0]          src_reg,   src_next;
  logic [1:0]          ace_reg,   ace_next;
  logic                ist_reg,   ist_next;
  logic                ien_reg,   ien_next;
  logic [31:0]         prd_reg,   prd_next;
  logic                err_reg,   err_next;
  logic [6:0]          div_reg,   div_next;
  acr_pkg::acr_state_e state_reg, state_next;
  logic [11:0]         sar_reg,   sar_next;
  logic [11:0]         res_reg,   res_next;
  logic [3:0]          bit_reg,   bit_next;
  logic [3:0]          stl_reg,   stl_next;
  logic                cmp_s1_reg;
  logic                cmp_s2_reg;

  logic        wr;
  logic        setup;
  logic        go;
  logic        done;
  logic        tick;
  logic        en;
  logic [6:0]  div_mask;
  logic [11:0] sar_keep;
  logic [31:0] rd_val;
  logic        hit;
  logic [2:0]  ins;
  logic        ext_src;

  assign en    = ctrl_reg[acr_pkg::CTRL_EN];
  assign ins   = src_reg[7:5];
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;
  // start fires on the write that takes the start bit from high to low
  assign go    = wr && paddr == acr_pkg::OFF_CTRL && ctrl_reg[acr_pkg::CTRL_START]
                 && !pwdata[acr_pkg::CTRL_START]; // RQ5

  // ==========================================================
  // apb read mux
  always_comb begin
    rd_val = 32'h0;
    hit    = 1'b1;
    unique case (paddr)
      acr_pkg::OFF_RES_LO:
        rd_val[7:0] = ctrl_reg[acr_pkg::CTRL_JUST] ? res_reg[7:0]
                                                   : {res_reg[3:0], 4'h0}; // RQ2 RQ3
      acr_pkg::OFF_RES_HI:
        rd_val[7:0] = ctrl_reg[acr_pkg::CTRL_JUST] ? {4'h0, res_reg[11:8]}
                                                   : res_reg[11:4]; // RQ2 RQ3
      acr_pkg::OFF_CTRL: begin
        rd_val[7:0]               = ctrl_reg;
        rd_val[acr_pkg::CTRL_BUSY] = conv_busy; // RQ6
      end
      acr_pkg::OFF_SRC:      rd_val[7:0] = src_reg;
      acr_pkg::OFF_ACE:      rd_val[1:0] = ace_reg;
      acr_pkg::OFF_IRQ_STAT: rd_val[0]   = ist_reg;
      acr_pkg::OFF_IRQ_CLR:  rd_val      = 32'h0;
      acr_pkg::OFF_IRQ_EN:   rd_val[0]   = ien_reg;
      default:               hit         = 1'b0;
    endcase
  end

  // ==========================================================
  // software registers
  always_comb begin
    ctrl_next = ctrl_reg;
    src_next  = src_reg;
    ace_next  = ace_reg;
    ien_next  = ien_reg;
    ist_next  = ist_reg;
    prd_next  = prd_reg;
    err_next  = err_reg;
    if (setup) begin
      // read data is taken in the setup cycle so that prdata comes from a flop
      prd_next = pwrite ? 32'h0 : rd_val;
      err_next = ~hit;
    end
    if (wr) begin
      unique case (paddr)
        acr_pkg::OFF_CTRL: begin
          ctrl_next                    = pwdata[7:0];
          ctrl_next[acr_pkg::CTRL_BUSY] = 1'b0; // RQ7
        end
        acr_pkg::OFF_SRC:     src_next = pwdata[7:0];
        acr_pkg::OFF_ACE:     ace_next = pwdata[1:0];
        acr_pkg::OFF_IRQ_EN:  ien_next = pwdata[0];
        acr_pkg::OFF_IRQ_CLR: ist_next = ist_reg & ~pwdata[0];
        default: ;
      endcase
    end
    // completion sets the flag even in the cycle software clears it
    if (done) begin
      ist_next = 1'b1; // RQ16
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= acr_pkg::RST_CTRL; // RQ14
      src_reg  <= acr_pkg::RST_SRC;
      ace_reg  <= acr_pkg::RST_ACE;
      ien_reg  <= 1'b0;
      ist_reg  <= 1'b0;
      prd_reg  <= 32'h0;
      err_reg  <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      src_reg  <= src_next;
      ace_reg  <= ace_next;
      ien_reg  <= ien_next;
      ist_reg  <= ist_next;
      prd_reg  <= prd_next;
      err_reg  <= err_next;
    end
  end

  assign prdata  = prd_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign irq     = ist_reg & ien_reg; // RQ16

  // ==========================================================
  // conversion clock divider
  assign div_mask = 7'((8'h1 << src_reg[2:0]) - 8'h1);
  assign tick     = (div_reg & div_mask) == div_mask; // RQ17

  always_comb begin
    // divider is held at zero while disabled to save toggling
    div_next = en ? 7'(div_reg + 7'h1) : 7'h0; // RQ8
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 7'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ==========================================================
  // comparator synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // ==========================================================
  // successive approximation
  // comparator high means input at or above the trial code
  assign sar_keep = cmp_s2_reg ? sar_reg : (sar_reg & ~(12'h1 << bit_reg));

  always_comb begin
    state_next = state_reg;
    sar_next   = sar_reg;
    bit_next   = bit_reg;
    stl_next   = stl_reg;
    res_next   = res_reg;
    done       = 1'b0;
    if (stl_reg != 4'h0) begin
      stl_next = 4'(stl_reg - 4'h1);
    end
    unique case (state_reg)
      acr_pkg::ACR_IDLE: begin
        if (go && en) begin // RQ5 RQ8
          state_next = acr_pkg::ACR_CONV; // RQ6
          sar_next   = acr_pkg::SAR_FIRST;
          bit_next   = acr_pkg::SAR_MSB;
          stl_next   = acr_pkg::SETTLE_CYC;
        end
      end
      acr_pkg::ACR_CONV: begin
        if (!en) begin
          // disabling aborts; the old result stays
          state_next = acr_pkg::ACR_IDLE; // RQ4
        end else if (tick && stl_reg == 4'h0) begin
          // settle count covers dac settling only, not the two synchroniser stages
          if (bit_reg == 4'h0) begin
            state_next = acr_pkg::ACR_IDLE; // RQ6
            res_next   = sar_keep; // RQ1 RQ18
            sar_next   = sar_keep;
            done       = 1'b1;
          end else begin
            sar_next                      = sar_keep;
            sar_next[4'(bit_reg - 4'h1)]  = 1'b1;
            bit_next                      = 4'(bit_reg - 4'h1);
            stl_next                      = acr_pkg::SETTLE_CYC;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= acr_pkg::ACR_IDLE;
      sar_reg   <= 12'h0;
      bit_reg   <= 4'h0;
      stl_reg   <= 4'h0;
      res_reg   <= 12'h0;
    end else begin
      state_reg <= state_next;
      sar_reg   <= sar_next;
      bit_reg   <= bit_next;
      stl_reg   <= stl_next;
      res_reg   <= res_next;
    end
  end

  assign conv_busy    = state_reg == acr_pkg::ACR_CONV; // RQ6
  assign dac_code     = sar_reg;
  assign adc_power_on = en; // RQ8
  assign ref_sel      = src_reg[4:3];

  // ==========================================================
  // analog input routing
  assign ext_src = ins == 3'h0 || ins > acr_pkg::INS_GND_HI; // RQ13
  always_comb begin
    route.pin0     = en && ext_src && ctrl_reg[3:0] == acr_pkg::CS_PIN0; // RQ9
    route.pin1     = en && ext_src && ctrl_reg[3:0] == acr_pkg::CS_PIN1; // RQ9
    route.internal = en && ins == acr_pkg::INS_INTERNAL; // RQ15
    route.ground   = en && ins >= acr_pkg::INS_GND_LO
                     && ins <= acr_pkg::INS_GND_HI; // RQ15
  end

  // ==========================================================
  // pin function control
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign pin_ctl[i].analog_en = ace_reg[i]; // RQ11
    assign pin_ctl[i].pullup_en = pin_pullup_req[i] & ~ace_reg[i]; // RQ12
  end

endmodule : acr_top
`default_nettype wire

// >>> verification/acr_props.sv
`timescale 1ns/10ps
`default_nettype none
module acr_props #(
  parameter int NUM_PINS = 2
) (
  input wire logic                             sys_clk,
  input wire logic                             rst,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [7:0]                       paddr,
  input wire logic [31:0]                      pwdata,
  input wire logic [11:0]                      dac_code,
  input wire logic                             adc_power_on,
  input wire acr_pkg::acr_route_s              route,
  input wire logic [NUM_PINS-1:0]              pin_pullup_req,
  input wire acr_pkg::acr_pin_s [NUM_PINS-1:0] pin_ctl,
  input wire logic                             conv_busy,
  input wire logic                             irq,
  input wire logic                             pslverr
);
  logic wr;
  logic go;
  logic start_reg;
  assign wr = psel & penable & pwrite;
  assign go = wr && paddr == acr_pkg::OFF_CTRL && start_reg && !pwdata[7]
              && adc_power_on && !conv_busy;
  // shadow of the stored start bit, the port alone cannot show it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_reg <= 1'b0;
    end else if (wr && paddr == acr_pkg::OFF_CTRL) begin
      start_reg <= pwdata[7];
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  busy_start_a: assert property (go |=> conv_busy && dac_code == acr_pkg::SAR_FIRST)
    else $error("no busy or first trial after start");
  busy_cause_a: assert property ($rose(conv_busy) |-> $past(go))
    else $error("busy rose without start sequence");
  busy_min_a: assert property ($rose(conv_busy) |-> conv_busy[*8])
    else $error("conversion ended too soon");
  power_off_a: assert property (!adc_power_on |=> !conv_busy)
    else $error("converting while disabled");
  route_off_a: assert property (!adc_power_on |-> route == 4'h0)
    else $error("input routed while disabled");
  route_onehot_a: assert property ($onehot0(route))
    else $error("two inputs routed at once");
  pullup_gate_a: assert property (pin_ctl[0].pullup_en == (pin_pullup_req[0] && !pin_ctl[0].analog_en))
    else $error("pull-high left on analog pin");
  irq_cause_a: assert property ($rose(irq) |-> $past(conv_busy) || $past(wr && paddr == acr_pkg::OFF_IRQ_EN))
    else $error("interrupt without completion");
  cover property ($fell(conv_busy));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule : acr_props
`default_nettype wire

// >>> verification/acr_analog.sv
`timescale 1ns/10ps
`default_nettype none
module acr_analog (
  input wire logic                sys_clk,
  input wire logic [11:0]         dac_code,
  input wire acr_pkg::acr_route_s route,
  input wire logic [11:0]         lvl0,
  input wire logic [11:0]         lvl1,
  input wire logic [11:0]         lvl2,
  output logic                    cmp_in
);
  // floating input wanders so an unrouted result is never stable
  logic flt = 1'b0;
  always @(posedge sys_clk) begin
    flt <= !flt;
  end
  always_comb begin
    if (route.pin0) begin
      cmp_in = lvl0 >= dac_code;
    end else if (route.pin1) begin
      cmp_in = lvl1 >= dac_code;
    end else if (route.internal) begin
      cmp_in = lvl2 >= dac_code;
    end else if (route.ground) begin
      cmp_in = dac_code == 12'h000;
    end else begin
      cmp_in = flt;
    end
  end
endmodule : acr_analog
`default_nettype wire

// >>> verification/acr_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module acr_top_bench;
  logic sys_clk, rst, psel, penable, pwrite, cmp_in, conv_busy, irq, pready, pslverr, adc_power_on;
  logic slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] dac_code;
  logic [1:0] ref_sel, pull;
  acr_pkg::acr_route_s route;
  acr_pkg::acr_pin_s [1:0] pin_ctl;
  int err_total, n_tests, cyc;
  logic [2:0] ins_t [4] = '{3'h2, 3'h4, 3'h5, 3'h1};
  logic [3:0] ch_t [4] = '{4'h2, 4'h3, 4'h1, 4'h2};
  logic [11:0] exp_t [4] = '{12'h000, 12'h000, 12'h3c7, 12'h5e1};
  acr_top i_acr_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .dac_code(dac_code), .adc_power_on(adc_power_on),
    .ref_sel(ref_sel), .route(route), .pin_pullup_req(pull), .pin_ctl(pin_ctl),
    .conv_busy(conv_busy), .irq(irq));
  acr_analog i_acr_analog (.sys_clk(sys_clk), .dac_code(dac_code), .route(route),
    .lvl0(12'ha5c), .lvl1(12'h3c7), .lvl2(12'h5e1), .cmp_in(cmp_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    slv = pslverr;
    if (n >= 100) begin
      $display("CHECK FAILED at %0t: no ready from slave", $time);
      err_total++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic res(input logic [11:0] v, input logic j);
    rd(acr_pkg::OFF_RES_HI, j ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
    rd(acr_pkg::OFF_RES_LO, j ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
  endtask : res
  task automatic conv(input logic [7:0] c);
    int n;
    n = 0;
    apb(1'b1, acr_pkg::OFF_CTRL, {24'h0, c | 8'h80});
    apb(1'b1, acr_pkg::OFF_CTRL, {24'h0, c});
    rd(acr_pkg::OFF_CTRL, {24'h0, c | {1'b0, c[5], 6'h0}});
    while (conv_busy !== 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    cyc = n;
    if (n >= 2000) begin
      $display("CHECK FAILED at %0t: busy never cleared", $time);
      err_total++;
      test_done();
    end
  endtask : conv
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pull} = {1'b1, 45'h0};
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), 32'h0);
    end
    $display("reset test done");
    apb(1'b1, acr_pkg::OFF_IRQ_EN, 32'h1);
    conv(8'h20);
    chk(32'(cyc < 80), 32'h1);
    res(12'ha5c, 1'b0);
    rd(acr_pkg::OFF_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, acr_pkg::OFF_IRQ_CLR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, acr_pkg::OFF_CTRL, 32'h70);
    rd(acr_pkg::OFF_CTRL, 32'h30);
    res(12'ha5c, 1'b1);
    $display("convert test done");
    apb(1'b1, acr_pkg::OFF_IRQ_EN, 32'h0);
    apb(1'b1, acr_pkg::OFF_SRC, 32'h03);
    conv(8'h20);
    chk(32'(cyc > 80), 32'h1);
    res(12'ha5c, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, acr_pkg::OFF_SRC, {24'h0, ins_t[i], 5'h0});
      conv({4'h2, ch_t[i]});
      res(exp_t[i], 1'b0);
    end
    chk({31'h0, irq}, 32'h0);
    rd(acr_pkg::OFF_IRQ_STAT, 32'h1);
    $display("source test done");
    apb(1'b1, acr_pkg::OFF_IRQ_CLR, 32'h1);
    // slow clock so the abort lands well inside the conversion
    apb(1'b1, acr_pkg::OFF_SRC, 32'h07);
    apb(1'b1, acr_pkg::OFF_CTRL, 32'ha0);
    apb(1'b1, acr_pkg::OFF_CTRL, 32'h20);
    rd(acr_pkg::OFF_CTRL, 32'h60);
    res(12'h5e1, 1'b0);
    apb(1'b1, acr_pkg::OFF_CTRL, 32'h00);
    rd(acr_pkg::OFF_CTRL, 32'h00);
    rd(acr_pkg::OFF_IRQ_STAT, 32'h0);
    apb(1'b1, acr_pkg::OFF_SRC, 32'h18);
    chk({30'h0, ref_sel}, 32'h3);
    conv(8'h00);
    res(12'h5e1, 1'b0);
    chk({31'h0, adc_power_on}, 32'h0);
    chk({28'h0, route}, 32'h0);
    $display("disable test done");
    pull <= 2'b11;
    apb(1'b1, acr_pkg::OFF_ACE, 32'h1);
    chk({28'h0, pin_ctl}, 32'h6);
    rd(acr_pkg::OFF_ACE, 32'h1);
    rd(8'h20, 32'h0);
    chk({31'h0, slv}, 32'h1);
    $display("pin and map test done");
    test_done();
  end
endmodule : acr_top_bench
bind acr_top acr_props #(.NUM_PINS(NUM_PINS)) u_props (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .dac_code(dac_code), .adc_power_on(adc_power_on), .route(route),
  .pin_pullup_req(pin_pullup_req), .pin_ctl(pin_ctl), .conv_busy(conv_busy), .irq(irq),
  .pslverr(pslverr));
`default_nettype wire
